// *** rtl/ao_waveform_timing_engine.sv ***
`timescale 1ns/1ps
// Contract
// - one hardware task, sixteen channels, software concurrent
// - reject module split between hardware and software
// - one conversion per software command, unpaced
// - single simultaneous task, unlimited, never with hardware
// - hardware samples always pass through fifo
// - finite mode stops after programmed count
// - continuous runs until stopped or a non-regeneration underflow, three sub-modes
// - regeneration: host refills fifo repeatedly
// - onboard: load once, replay, refuse writes
// - non-regeneration never replays, flags underflow
// - strobe updates all channels, source selectable
// - strobe divided from timebase, timebase never output
// - strobe routable to any output function line
// - start on trigger or software command
// - delay trigger to first sample, internal strobe
// - trigger source selectable, rising or falling edge
// - analog crossing start uses first selected edge
// - routed start trigger is active-high pulse
// - hold blocks new samples from next sample
// - onboard clock resumes at hold release
// - other strobe resumes on next edge after release
// - hold is level sensitive, polarity, selectable source
module ao_waveform_timing_engine
  import ao_wave_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic smp_valid,
  input wire logic [DATA_W-1:0] smp_data,
  output logic smp_ready,
  input wire logic [PFI_N-1:0] pfi_in,
  output logic [PFI_N-1:0] pfi_out,
  output logic [PFI_N-1:0] pfi_oe,
  input wire logic acquire_reference_trigger,
  input wire logic acquire_go_trigger,
  input wire logic analog_cross_event,
  input wire logic internal_go_signal,
  input wire logic internal_hold_signal,
  output mod_update_s mod_update
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int LW = PW + 1;
  localparam logic [LW-1:0] FIFO_FULL_LVL = LW'(FIFO_DEPTH);

  // every piece of state but the sample store in one record
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    mode_reg_s mode;
    logic [15:0] div;
    logic [15:0] delay;
    logic [31:0] count;
    logic [CHAN_N-1:0] hwmask;
    logic [CHAN_N-1:0] swmask;
    logic [PFI_N-1:0] route_oe;
    logic [PFI_N-1:0] route_go;
    seq_e seq;
    logic [15:0] tick_cnt;
    logic [15:0] delay_cnt;
    logic [31:0] samples;
    logic underflow;
    logic done;
    logic simul_busy;
    logic paused;
    logic kick;
    logic go_prev;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] head_ptr;
    logic [PW-1:0] last_ptr;
    logic [LW-1:0] level;
    logic [PFI_N-1:0] s1;
    logic [PFI_N-1:0] s2;
    logic [PFI_N-1:0] s3;
    logic [PFI_N-1:0] filt;
    logic [PFI_N-1:0] filt_prev;
    logic go_pulse;
    logic strobe_pulse;
    logic [PFI_N-1:0] pfi_out;
    mod_update_s upd;
  } st_s;

  st_s s_q;
  st_s s_d;
  logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];  // sample store
  logic push;  // host word accepted this cycle
  logic running;  // a hardware task owns the fifo
  logic go_raw;  // selected trigger level
  logic go_edge;  // selected edge seen
  logic hold_raw;
  logic hold_act;
  logic onboard;  // strobe from the divided onboard clock
  logic tb_tick;  // one timebase period
  logic ext_strobe;
  logic [PFI_N-1:0] rise;
  logic [31:0] stat;

  // byte-enable merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // number of channels claimed by the hardware task
  function automatic int unsigned ones(input logic [CHAN_N-1:0] v);
    int unsigned c;
    c = 0;
    for (int i = 0; i < CHAN_N; i++) begin
      c = c + int'(v[i]);
    end
    return c;
  endfunction

  assign running = (s_q.seq != SEQ_IDLE) && (s_q.seq != SEQ_DONE);
  // onboard replay locks the fifo once started; full always holds off the host
  assign smp_ready = (s_q.level != FIFO_FULL_LVL) && !(running && s_q.mode.mode == MODE_ONBOARD);
  assign push = smp_valid && smp_ready;
  // answer one cycle after the request is seen
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign pfi_out = s_q.pfi_out;
  assign pfi_oe = s_q.route_oe;
  assign mod_update = s_q.upd;

  // next-state logic for bus, synchronisers and sequencer
  always_comb begin
    logic cfg_err;  // configuration that must be refused
    logic [31:0] wd;  // merged write value
    logic wr_start;
    logic wr_stop;
    logic host_pulse;
    logic div_strobe;
    logic sample;  // a sample starts now
    logic pop;
    s_d = s_q;
    cfg_err = 1'b0;
    wd = 32'h0000_0000;
    wr_start = 1'b0;
    wr_stop = 1'b0;
    host_pulse = 1'b0;
    sample = 1'b0;
    pop = 1'b0;
    div_strobe = 1'b0;
    // pulse outputs last one cycle
    s_d.ack = 1'b0;
    s_d.go_pulse = 1'b0;
    s_d.strobe_pulse = 1'b0;
    s_d.upd.hw_strobe = 1'b0;
    s_d.upd.sw_strobe = 1'b0;

    // pin synchronisers: a high counts once stages two and three agree, and drops as soon as they differ
    s_d.s1 = pfi_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.filt = (s_q.s2 & s_q.s3) | (s_q.filt & ~(s_q.s2 ^ s_q.s3));
    s_d.filt_prev = s_q.filt;
    rise = s_q.filt & ~s_q.filt_prev;

    // a module may not be split between the two kinds of task
    for (int m = 0; m < MOD_N; m++) begin
      if ((|s_q.hwmask[m*CH_PER_MOD +: CH_PER_MOD]) && (|s_q.swmask[m*CH_PER_MOD +: CH_PER_MOD])) begin
        cfg_err = 1'b1;
      end
    end
    if (ones(s_q.hwmask) > HW_CHAN_MAX) begin
      cfg_err = 1'b1;
    end

    // status word
    stat = 32'h0000_0000;
    stat[4:0] = s_q.seq;
    stat[STAT_UNDERFLOW] = s_q.underflow;
    stat[STAT_DONE] = s_q.done;
    stat[STAT_CFG_ERR] = cfg_err;
    stat[STAT_SIMUL] = s_q.simul_busy;
    stat[STAT_HOLD] = s_q.paused;
    stat[STAT_FULL] = (s_q.level == FIFO_FULL_LVL);
    stat[STAT_LEVEL +: LW] = s_q.level;

    // avalon slave: take request, answer next edge
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack = 1'b1;
      if (avs_read) begin
        case (avs_address)
          OFS_MODE: s_d.rdata = s_q.mode;
          OFS_DIV: s_d.rdata = {16'h0000, s_q.div};
          OFS_DELAY: s_d.rdata = {16'h0000, s_q.delay};
          OFS_COUNT: s_d.rdata = s_q.count;
          OFS_HWMASK: s_d.rdata = s_q.hwmask;
          OFS_SWMASK: s_d.rdata = s_q.swmask;
          OFS_ROUTE: s_d.rdata = {16'h0000, s_q.route_go, s_q.route_oe};
          OFS_STATUS: s_d.rdata = stat;
          OFS_SAMPLES: s_d.rdata = s_q.samples;
          default: s_d.rdata = 32'h0000_0000;  // unmapped and write-only read zero
        endcase
      end
    end
    // a write lands where waitrequest is low
    if (avs_write && s_q.ack) begin
        case (avs_address)
          OFS_CTRL: begin
            wd = avs_byteenable[0] ? avs_writedata : 32'h0000_0000;
            wr_start = wd[CTRL_START];
            wr_stop = wd[CTRL_STOP];
            host_pulse = wd[CTRL_HOST_PULSE];
            if (wd[CTRL_SIMUL_CLAIM] && !running && !cfg_err) begin
              s_d.simul_busy = 1'b1;
            end
            if (wd[CTRL_SIMUL_FREE]) begin
              s_d.simul_busy = 1'b0;
            end
            if (wd[CTRL_CLR_ERR]) begin
              s_d.underflow = 1'b0;  // a later set in this cycle still wins
            end
          end
          // timing setup only changes while idle
          OFS_MODE: if (!running) begin
            s_d.mode = be_merge(s_q.mode, avs_writedata, avs_byteenable);
          end
          OFS_DIV: if (!running) begin
            wd = be_merge({16'h0000, s_q.div}, avs_writedata, avs_byteenable);
            s_d.div = wd[15:0];
          end
          OFS_DELAY: if (!running) begin
            wd = be_merge({16'h0000, s_q.delay}, avs_writedata, avs_byteenable);
            s_d.delay = wd[15:0];
          end
          OFS_COUNT: if (!running) begin
            s_d.count = be_merge(s_q.count, avs_writedata, avs_byteenable);
          end
          OFS_HWMASK: if (!running) begin
            s_d.hwmask = be_merge(s_q.hwmask, avs_writedata, avs_byteenable);
          end
          OFS_SWMASK: s_d.swmask = be_merge(s_q.swmask, avs_writedata, avs_byteenable);
          OFS_SWDATA: begin
            // each command is exactly one conversion; no pacing here
            if (!cfg_err && !(s_q.simul_busy && running)) begin
              s_d.upd.sw_strobe = 1'b1;
              s_d.upd.sw_data = avs_writedata[DATA_W-1:0];
              s_d.upd.sw_mask = s_q.swmask;
              s_d.upd.sw_simul = s_q.simul_busy;
            end
          end
          OFS_ROUTE: begin
            wd = be_merge({16'h0000, s_q.route_go, s_q.route_oe}, avs_writedata, avs_byteenable);
            s_d.route_oe = wd[7:0];
            s_d.route_go = wd[15:8];
          end
          default: ;  // unmapped writes are dropped
        endcase
    end

    // start trigger source and edge
    case (s_q.mode.go_src)
      GO_HOST: go_raw = host_pulse;
      GO_PFI: go_raw = s_q.filt[s_q.mode.go_pfi[2:0]];
      GO_ACQ_REF: go_raw = acquire_reference_trigger;
      GO_ACQ_GO: go_raw = acquire_go_trigger;
      GO_ANALOG: go_raw = analog_cross_event;
      GO_INTERNAL: go_raw = internal_go_signal;
      default: go_raw = 1'b0;
    endcase
    s_d.go_prev = go_raw;
    go_edge = s_q.mode.go_falling ? (s_q.go_prev && !go_raw) : (!s_q.go_prev && go_raw);

    // hold level and polarity
    case (s_q.mode.hold_src)
      HOLD_PFI: hold_raw = s_q.filt[s_q.mode.hold_pfi[2:0]];
      HOLD_INTERNAL: hold_raw = internal_hold_signal;
      HOLD_ANALOG: hold_raw = analog_cross_event;
      default: hold_raw = 1'b0;
    endcase
    hold_act = s_q.mode.hold_en && (hold_raw == s_q.mode.hold_high);

    // timebase: the system clock itself or an edge on a function line
    onboard = !s_q.mode.tb_ext && !s_q.mode.strobe_ext;
    tb_tick = s_q.mode.tb_ext ? rise[s_q.mode.tb_pfi[2:0]] : 1'b1;
    ext_strobe = rise[s_q.mode.strobe_pfi[2:0]];

    // sequencer
    case (s_q.seq)
      SEQ_IDLE, SEQ_DONE: begin
        s_d.tick_cnt = 16'h0000;
        s_d.paused = 1'b0;
        // refused while misconfigured or a simultaneous task holds the modules
        if (wr_start && !cfg_err && !s_q.simul_busy) begin
          s_d.done = 1'b0;
          s_d.samples = 32'h0000_0000;
          s_d.head_ptr = s_q.rd_ptr;
          s_d.last_ptr = s_q.wr_ptr - PW'(1);
          s_d.seq = s_q.mode.go_en ? SEQ_ARMED : SEQ_DELAY;
          s_d.delay_cnt = 16'h0000;
        end
      end
      SEQ_ARMED: begin
        if (go_edge) begin
          s_d.go_pulse = 1'b1;
          s_d.seq = SEQ_DELAY;
          s_d.delay_cnt = 16'h0000;
        end
      end
      SEQ_DELAY: begin
        // the delay is counted only when the strobe is made internally
        if (s_q.mode.strobe_ext || s_q.delay_cnt >= s_q.delay) begin
          s_d.seq = SEQ_RUN;
          s_d.kick = !s_q.mode.strobe_ext;
        end else if (tb_tick) begin
          s_d.delay_cnt = s_q.delay_cnt + 16'h0001;
        end
      end
      SEQ_RUN: begin
        if (tb_tick) begin
          if (s_q.tick_cnt + 16'h0001 >= s_q.div) begin
            div_strobe = 1'b1;
            s_d.tick_cnt = 16'h0000;
          end else begin
            s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
          end
        end
        if (hold_act) begin
          // nothing new starts; an update already issued completes
          s_d.paused = 1'b1;
          if (onboard) begin
            s_d.tick_cnt = 16'h0000;
          end
        end else if (s_q.paused && onboard) begin
          sample = 1'b1;
          s_d.paused = 1'b0;
          s_d.tick_cnt = 16'h0000;
        end else if (s_q.kick) begin
          sample = 1'b1;
          s_d.kick = 1'b0;
          s_d.tick_cnt = 16'h0000;
        end else begin
          // other sources wait for the next strobe edge after release
          sample = s_q.mode.strobe_ext ? ext_strobe : div_strobe;
          if (sample) begin
            s_d.paused = 1'b0;
          end
        end
        if (sample) begin
          s_d.strobe_pulse = 1'b1;
          if (s_q.level == '0) begin
            // an empty fifo is an error only in non-regeneration mode
            if (s_q.mode.mode == MODE_NOREGEN) begin
              s_d.underflow = 1'b1;
              s_d.seq = SEQ_IDLE;
            end
          end else begin
            // all channels of the task take the same strobe
            s_d.upd.hw_strobe = 1'b1;
            s_d.upd.hw_data = fifo_mem[s_q.rd_ptr];
            s_d.upd.hw_mask = s_q.hwmask;
            s_d.samples = s_q.samples + 32'h0000_0001;
            if (s_q.mode.mode == MODE_ONBOARD) begin
              s_d.rd_ptr = (s_q.rd_ptr == s_q.last_ptr) ? s_q.head_ptr : s_q.rd_ptr + PW'(1);
            end else begin
              pop = 1'b1;
              s_d.rd_ptr = s_q.rd_ptr + PW'(1);
            end
            if (s_q.mode.mode == MODE_FINITE && s_q.samples + 32'h0000_0001 >= s_q.count) begin
              s_d.seq = SEQ_DONE;
              s_d.done = 1'b1;
            end
          end
        end
      end
      default: s_d.seq = SEQ_IDLE;
    endcase

    // stop ends any running task; non-regeneration also ends on underflow
    if (wr_stop && running) begin
      s_d.seq = SEQ_IDLE;
    end

    // fifo bookkeeping
    if (push) begin
      s_d.wr_ptr = s_q.wr_ptr + PW'(1);
    end
    s_d.level = s_q.level + LW'(push) - LW'(pop);

    // function line drive: start pulse or strobe, never the timebase
    for (int i = 0; i < PFI_N; i++) begin
      s_d.pfi_out[i] = s_q.route_go[i] ? s_d.go_pulse : s_d.strobe_pulse;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.seq <= SEQ_IDLE;
      s_q.div <= DIV_RST;
      s_q.delay <= DELAY_RST;
      s_q.count <= COUNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // sample store; no reset needed, level guards reads
  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifo_mem[s_q.wr_ptr] <= smp_data;
    end
  end

endmodule

// *** rtl/ao_wave_pkg.sv ***
package ao_wave_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_MODE = 6'h04;
  localparam logic [5:0] OFS_DIV = 6'h08;
  localparam logic [5:0] OFS_DELAY = 6'h0C;
  localparam logic [5:0] OFS_COUNT = 6'h10;
  localparam logic [5:0] OFS_HWMASK = 6'h14;
  localparam logic [5:0] OFS_SWMASK = 6'h18;
  localparam logic [5:0] OFS_SWDATA = 6'h1C;
  localparam logic [5:0] OFS_ROUTE = 6'h20;
  localparam logic [5:0] OFS_STATUS = 6'h24;
  localparam logic [5:0] OFS_SAMPLES = 6'h28;

  // command bit positions in the control register (write-only pulses)
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_HOST_PULSE = 2;
  localparam int CTRL_SIMUL_CLAIM = 3;
  localparam int CTRL_SIMUL_FREE = 4;
  localparam int CTRL_CLR_ERR = 5;

  // status bit positions
  localparam int STAT_UNDERFLOW = 5;
  localparam int STAT_DONE = 6;
  localparam int STAT_CFG_ERR = 7;
  localparam int STAT_SIMUL = 8;
  localparam int STAT_HOLD = 9;
  localparam int STAT_FULL = 10;
  localparam int STAT_LEVEL = 16;

  // values after reset
  localparam logic [15:0] DIV_RST = 16'h0064;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0400;

  // fixed chassis geometry
  localparam int DATA_W = 16;
  localparam int CHAN_N = 32;
  localparam int CH_PER_MOD = 4;
  localparam int MOD_N = 8;
  localparam int PFI_N = 8;
  localparam int HW_CHAN_MAX = 16;

  typedef enum logic [1:0] {
    MODE_FINITE = 2'h0,
    MODE_REGEN = 2'h1,
    MODE_ONBOARD = 2'h2,
    MODE_NOREGEN = 2'h3
  } gen_mode_e;

  typedef enum logic [2:0] {
    GO_HOST = 3'h0,
    GO_PFI = 3'h1,
    GO_ACQ_REF = 3'h2,
    GO_ACQ_GO = 3'h3,
    GO_ANALOG = 3'h4,
    GO_INTERNAL = 3'h5
  } go_src_e;

  typedef enum logic [1:0] {
    HOLD_PFI = 2'h0,
    HOLD_INTERNAL = 2'h1,
    HOLD_ANALOG = 2'h2
  } hold_src_e;

  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01,
    SEQ_ARMED = 5'h02,
    SEQ_DELAY = 5'h04,
    SEQ_RUN = 5'h08,
    SEQ_DONE = 5'h10
  } seq_e;

  // layout of the mode register
  typedef struct packed {
    logic [3:0] tb_pfi;
    logic [3:0] strobe_pfi;
    logic [3:0] hold_pfi;
    logic [3:0] go_pfi;
    logic rsvd_a;
    hold_src_e hold_src;
    logic hold_high;
    logic hold_en;
    go_src_e go_src;
    logic [1:0] rsvd_b;
    logic go_falling;
    logic go_en;
    logic strobe_ext;
    logic tb_ext;
    gen_mode_e mode;
  } mode_reg_s;

  // update requests towards the output modules
  typedef struct packed {
    logic hw_strobe;
    logic [CHAN_N-1:0] hw_mask;
    logic [DATA_W-1:0] hw_data;
    logic sw_strobe;
    logic sw_simul;
    logic [CHAN_N-1:0] sw_mask;
    logic [DATA_W-1:0] sw_data;
  } mod_update_s;

endpackage

// *** verif/ao_wave_checker.sv ***
`timescale 1ns/1ps
// watches the update outputs against what software configured
module ao_wave_checker
  import ao_wave_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic internal_hold_signal,
  input wire mod_update_s mod_update
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic acc; // write taken at this edge
  logic sw_cmd_w; // software data write taken
  logic hold_act; // internal hold at its active level
  mode_reg_s mode_q; // shadow of the mode register
  logic [15:0] div_q; // shadow of the divider
  logic [15:0] div_eff; // zero acts as one
  logic [15:0] gap_q; // cycles since last strobe, saturating
  logic [31:0] mask_q; // shadow of the hardware mask
  assign acc = avs_write && !avs_waitrequest;
  assign sw_cmd_w = acc && avs_address == OFS_SWDATA;
  assign div_eff = (div_q == 16'h0000) ? 16'h0001 : div_q;
  assign hold_act = mode_q.hold_en && mode_q.hold_src == HOLD_INTERNAL && internal_hold_signal == mode_q.hold_high;
  // shadows are only right if software configures while idle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_q <= '0;
      div_q <= DIV_RST;
      mask_q <= '0;
      gap_q <= 16'hFFFF;
    end else begin
      if (acc && avs_address == OFS_MODE) mode_q <= avs_writedata;
      if (acc && avs_address == OFS_DIV) div_q <= avs_writedata[15:0];
      if (acc && avs_address == OFS_HWMASK) mask_q <= avs_writedata;
      // saturate so a long idle never wraps into a short gap
      if (mod_update.hw_strobe) gap_q <= 16'h0001;
      else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
    end
  end
  // a data write followed by its single conversion
  sequence sw_fire;
    sw_cmd_w ##1 mod_update.sw_strobe;
  endsequence
  // hold seen at three edges in a row
  sequence held;
    hold_act [*3];
  endsequence
  AST_SW_CAUSE: assert property (mod_update.sw_strobe |-> $past(sw_cmd_w))
    else $error("software update without a data write");
  AST_SW_DATA: assert property (sw_fire |-> mod_update.sw_data == $past(avs_writedata[15:0]))
    else $error("software update carries wrong data");
  AST_SW_ONCE: assert property (mod_update.sw_strobe |=> !mod_update.sw_strobe)
    else $error("software update repeated");
  AST_SIMUL_ALONE: assert property (mod_update.sw_strobe && mod_update.sw_simul |-> !mod_update.hw_strobe)
    else $error("simultaneous update beside hardware update");
  AST_HW_LIMIT: assert property (mod_update.hw_strobe |-> $countones(mod_update.hw_mask) <= HW_CHAN_MAX)
    else $error("hardware task wider than allowed");
  AST_HW_ALL: assert property (mod_update.hw_strobe |-> mod_update.hw_mask == mask_q)
    else $error("strobe does not cover all task channels");
  AST_DIV_GAP: assert property (mod_update.hw_strobe && !mode_q.hold_en && !mode_q.strobe_ext && !mode_q.tb_ext
    |-> gap_q >= div_eff)
    else $error("strobes closer than the divider");
  AST_HOLD_BLOCK: assert property (held |-> !mod_update.hw_strobe)
    else $error("sample issued during hold");
endmodule

bind ao_waveform_timing_engine ao_wave_checker #(.FIFO_DEPTH(FIFO_DEPTH)) ao_wave_checker_i (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .avs_address(avs_address),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest),
  .internal_hold_signal(internal_hold_signal),
  .mod_update(mod_update)
);

// *** verif/host_feeder.sv ***
`timescale 1ns/1ps
// host transfer logic pushing counting sample words
module host_feeder
  import ao_wave_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic run,
  input wire logic smp_ready,
  output logic smp_valid,
  output logic [DATA_W-1:0] smp_data
);
  logic [DATA_W-1:0] word_q; // next word to hand over
  // released line shows the inverse, never a stale copy
  assign smp_data = smp_valid ? word_q : ~word_q;
  // word held until taken; a full fifo stalls us
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      smp_valid <= 1'b0;
      word_q <= '0;
    end else if (smp_valid && smp_ready) begin
      word_q <= word_q + 16'h0001;
      smp_valid <= run;
    end else if (!smp_valid) begin
      smp_valid <= run;
    end
  end
endmodule

// *** verif/ao_waveform_timing_engine_bench.sv ***
`timescale 1ns/1ps
module ao_waveform_timing_engine_bench import ao_wave_pkg::*;;
  localparam logic W = 1'b1; // write cycle
  localparam logic R = 1'b0; // read cycle
  typedef struct packed {logic wr; logic [5:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  row_s rows [8]; // register cases
  logic clk_sys, resetn, avs_read, avs_write, run, hold, chk;
  logic avs_waitrequest, smp_valid, smp_ready;
  logic go_q = 1'b0; // last start pulse level
  logic [5:0] avs_address, trg; // trg indexed by start source
  logic [31:0] avs_writedata, avs_readdata, st;
  logic [DATA_W-1:0] smp_data, exp_d;
  logic [PFI_N-1:0] pfi_out, pfi_oe;
  mod_update_s mod_update;
  int errors = 0, tests_run = 0, ns = 0, nsw = 0, ngo = 0, n0, m;
  ao_waveform_timing_engine #(.FIFO_DEPTH(8)) ao_waveform_timing_engine_i (
    .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .smp_valid(smp_valid),
    .smp_data(smp_data), .smp_ready(smp_ready), .pfi_in({6'h00, trg[1], 1'b0}), .pfi_out(pfi_out),
    .pfi_oe(pfi_oe), .acquire_reference_trigger(trg[2]), .acquire_go_trigger(trg[3]),
    .analog_cross_event(trg[4]), .internal_go_signal(trg[5]), .internal_hold_signal(hold),
    .mod_update(mod_update));
  host_feeder host_feeder_i (.clk_sys(clk_sys), .resetn(resetn), .run(run), .smp_ready(smp_ready),
    .smp_valid(smp_valid), .smp_data(smp_data));
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon cycle, held until waitrequest is low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest);
    st = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // bounded status poll; the compare after it catches a miss
  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      bus(R, OFS_STATUS, 32'h0);
      k++;
    end while (!st[b] && k < 400);
  endtask
  // stop, configure, start
  task automatic go(input logic [31:0] md);
    bus(W, OFS_CTRL, 32'h2);
    bus(W, OFS_MODE, md);
    bus(W, OFS_CTRL, 32'h1);
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // counters on the falling edge so the main flow reads them race free
  always @(negedge clk_sys) begin
    if (!resetn) exp_d = '0;
    else if (mod_update.hw_strobe) begin
      ns++;
      ck({31'h0, pfi_out[3]}, 32'h1);
      if (chk) ck({16'h0, mod_update.hw_data}, {16'h0, exp_d});
      exp_d = exp_d + 16'h0001;
    end
    if (mod_update.sw_strobe) nsw++;
    if (pfi_out[2] && !go_q) ngo++;
    go_q = pfi_out[2];
  end
  // hang guard, far beyond the expected run
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
  initial begin
    rows = '{'{R, OFS_DIV, 32'h0, 32'h64}, '{R, OFS_DELAY, 32'h0, 32'h0},
      '{R, OFS_COUNT, 32'h0, 32'h400}, '{R, OFS_STATUS, 32'h0, 32'h1}, '{W, OFS_DIV, 32'h5, 32'h5},
      '{W, OFS_COUNT, 32'h7, 32'h7}, '{W, 6'h2C, 32'h55, 32'h0}, '{W, OFS_ROUTE, 32'h40C, 32'h40C}};
    {resetn, avs_read, avs_write, run, hold, chk} = 6'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    trg = 6'h00;
    cyc(5);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) bus(W, rows[i].a, rows[i].d);
      bus(R, rows[i].a, 32'h0);
      ck(st, rows[i].e);
    end
    ck({24'h0, pfi_oe}, 32'hC);
    // fifo fills while idle and then refuses
    run <= 1'b1;
    cyc(30);
    bus(R, OFS_STATUS, 32'h0);
    ck(st & 32'h007F_041F, 32'h0008_0401);
    ck({31'h0, smp_ready}, 32'h0);
    // module split, oversize task, software updates, simultaneous claim
    bus(W, OFS_HWMASK, 32'h1);
    bus(W, OFS_SWMASK, 32'h2);
    n0 = nsw;
    bus(W, OFS_SWDATA, 32'h0);
    bus(W, OFS_CTRL, 32'h1);
    bus(R, OFS_STATUS, 32'h0);
    ck(st & 32'h9F, 32'h81);
    ck(32'(nsw - n0), 32'h0);
    bus(W, OFS_HWMASK, 32'h1FFFF);
    bus(W, OFS_SWMASK, 32'h0);
    bus(R, OFS_STATUS, 32'h0);
    ck(st & 32'h80, 32'h80);
    bus(W, OFS_HWMASK, 32'hF);
    bus(W, OFS_SWMASK, 32'hF0);
    bus(W, OFS_SWDATA, 32'h1234);
    bus(W, OFS_SWDATA, 32'h1235);
    cyc(1);
    ck(32'(nsw - n0), 32'h2);
    bus(W, OFS_CTRL, 32'h8);
    bus(W, OFS_SWDATA, 32'h55);
    bus(W, OFS_CTRL, 32'h1);
    bus(R, OFS_STATUS, 32'h0);
    ck(st & 32'h19F, 32'h101);
    bus(W, OFS_CTRL, 32'h10);
    // finite run stops on its own after the count
    chk <= 1'b1;
    bus(W, OFS_DIV, 32'h4);
    bus(W, OFS_COUNT, 32'h5);
    n0 = ns;
    go(32'h0);
    poll(STAT_DONE);
    cyc(20);
    ck(st & 32'h5F, 32'h50);
    ck(32'(ns - n0), 32'h5);
    // every start source, alternating edges, with a start delay
    bus(W, OFS_DELAY, 32'hC);
    for (int s = 0; s < 6; s++) begin
      trg <= s[0] ? 6'h3F : 6'h00;
      go({12'h0, 4'h1, 5'h0, 3'(s), 2'h0, s[0], 1'b1, 4'h0});
      bus(R, OFS_STATUS, 32'h0);
      ck(st & 32'h1F, 32'h2);
      n0 = ns;
      m = ngo;
      if (s == 0) bus(W, OFS_CTRL, 32'h4);
      else trg[s] <= !trg[s];
      cyc(10);
      ck(32'(ns - n0), 32'h0);
      poll(STAT_DONE);
      ck(32'(ngo - m), 32'h1);
      ck(32'(ns - n0), 32'h5);
    end
    // regeneration with internal hold, active high
    bus(W, OFS_DELAY, 32'h0);
    go(32'h3801);
    cyc(10);
    hold <= 1'b1;
    cyc(3);
    n0 = ns;
    cyc(30);
    bus(R, OFS_STATUS, 32'h0);
    ck(32'(ns - n0), 32'h0);
    ck(st & 32'h21F, 32'h208);
    hold <= 1'b0;
    n0 = ns;
    cyc(3);
    ck(32'(ns - n0), 32'h1);
    cyc(60);
    bus(R, OFS_STATUS, 32'h0);
    ck(st & 32'h1F, 32'h8);
    // no fresh data: drains in order, then underflow
    run <= 1'b0;
    go(32'h3);
    poll(STAT_UNDERFLOW);
    ck(st & 32'h3F, 32'h21);
    bus(W, OFS_CTRL, 32'h20);
    bus(R, OFS_STATUS, 32'h0);
    ck(st & 32'h20, 32'h0);
    // onboard replay refuses the host and never runs dry; then an external strobe on a function line
    chk <= 1'b0;
    run <= 1'b1;
    cyc(30);
    go(32'h2);
    cyc(5);
    ck({31'h0, smp_ready}, 32'h0);
    n0 = ns;
    cyc(40);
    ck(32'(ns - n0), 32'hA);
    trg <= 6'h00;
    go(32'h0100_0009);
    n0 = ns;
    repeat (6) begin
      trg[1] <= !trg[1];
      cyc(4);
    end
    ck(32'(ns - n0), 32'h3);
    // reset in mid run
    resetn <= 1'b0;
    cyc(5);
    ck({31'h0, |mod_update}, 32'h0);
    resetn <= 1'b1;
    bus(R, OFS_DIV, 32'h0);
    ck(st, 32'h64);
    tally_and_finish();
  end
endmodule
